// ### hdl/usb_dev_cfg.svh
`ifndef USB_DEV_CFG_SVH
`define USB_DEV_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_FRAME     8'h00
`define OFF_GLOBAL    8'h04
`define OFF_FADDR     8'h08
`define OFF_IRQ_SET   8'h10
`define OFF_IRQ_CLR   8'h14
`define OFF_IRQ_MASK  8'h18
`define OFF_IRQ_STAT  8'h1C
`define OFF_STAT_CLR  8'h20
`define OFF_FRAME_B8  8'h78

// ****************************************************************
// Field positions
// ****************************************************************
`define FRAME_ERR_BIT 16
`define FRAME_OK_BIT  17
`define B8_OK_BIT     12
`define B8_ERR_BIT    3
`define GS_ADDR_BIT   0
`define GS_CONF_BIT   1
`define GS_RSMEN_BIT  2
`define GS_RSM_BIT    3
`define GS_WAKE_BIT   4
`define FA_EN_BIT     8
`define IRQ_SUSP_BIT  8
`define IRQ_RSM_BIT   9
`define IRQ_EXT_BIT   10
`define IRQ_SOF_BIT   11
`define IRQ_BRST_BIT  12
`define IRQ_WAKE_BIT  13

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define GLOBAL_RST    5'h10
`define FADDR_RST     7'h00
`define FUNC_EN_RST   1'b1
`define MASK_RST      14'h1200
`define MASK_WR       14'h2F3F
`define STAT_RST      14'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define SUSPEND_IDLE_US  3000
`define REF_CLK_MHZ      250

`endif

// ### hdl/usb_dev_pkg.sv
package usb_dev_pkg;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ_WAIT,
        PH_READ_DONE
    } bus_phase_e;

    typedef logic [13:0] irq_vec_t;

endpackage

// ### hdl/usb_device_state_ctrl.sv
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "usb_dev_cfg.svh"

// Functional notes
// - Bad SOF end sets error; PID clears it.
// - Clean SOF end sets good; PID clears it.
// - SOF status sets on PID, not end.
// - Bytes: good high bit 4, error low bit 3.
// - Bit 0 reads address state.
// - Writing 0 to address state does nothing.
// - Bit 1 configured flag, read and write.
// - Bit 2 enables remote wake and resume pin.
// - Bit 3 flags host resume during remote wake.
// - Bit 4 with enable drives K-state.
// - Seven-bit address, zero after reset.
// - Function enable gates endpoints, reads back.
// - Enable register sets mask bits on ones.
// - Disable register clears mask bits on ones; bus reset bit 12 stays set.
// - Mask register reads enabled sources.
// - Three ms idle raises suspend status.
module usb_device_state_ctrl #(
    parameter int IDLE_LIMIT = `SUSPEND_IDLE_US * `REF_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // USB link events
    input  wire logic        sofPidSeen,
    input  wire logic        sofEopSeen,
    input  wire logic        sofCrcError,
    input  wire logic [10:0] frameNumberIn,
    input  wire logic        busActivity,
    input  wire logic        hostResumeSeen,
    input  wire logic        busResetEnd,
    input  wire logic        sendResumePin,
    input  wire logic [5:0]  endpointIrq,
    // Device state outputs
    output logic             driveKState,
    output logic             endpointsEnabled,
    output logic [6:0]       deviceAddress,
    output logic             addressStateOut,
    output logic             configuredOut,
    output logic             suspendedOut,
    output logic             irq
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    usb_dev_pkg::bus_phase_e phase_q;
    logic [7:0]              addr_q;
    logic [31:0]             rdata_q;
    logic                    addrPhase;
    logic                    wrEn;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign addrPhase = hsel && htrans[1] && hready;
    assign wrEn      = (phase_q == usb_dev_pkg::PH_WRITE);
    assign hreadyout = (phase_q != usb_dev_pkg::PH_READ_WAIT);
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            phase_q <= usb_dev_pkg::PH_IDLE;
            addr_q  <= 8'h00;
        end
        else
        begin
            unique case (phase_q)
                usb_dev_pkg::PH_READ_WAIT:
                    phase_q <= usb_dev_pkg::PH_READ_DONE;
                usb_dev_pkg::PH_IDLE,
                usb_dev_pkg::PH_WRITE,
                usb_dev_pkg::PH_READ_DONE:
                begin
                    if (addrPhase)
                    begin
                        phase_q <= hwrite ? usb_dev_pkg::PH_WRITE
                                          : usb_dev_pkg::PH_READ_WAIT;
                        addr_q  <= {haddr[7:2], 2'b00};
                    end
                    else
                    begin
                        phase_q <= usb_dev_pkg::PH_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Frame flags
    // ****************************************************************
    logic [10:0] frameNum_q;
    logic        frameErr_q;
    logic        frameOk_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            frameNum_q <= 11'h000;
            frameErr_q <= 1'b0;
            frameOk_q  <= 1'b0;
        end
        else if (sofEopSeen)
        begin
            frameNum_q <= frameNumberIn;
            frameErr_q <= sofCrcError;
            frameOk_q  <= !sofCrcError;
        end
        else if (sofPidSeen)
        begin
            frameErr_q <= 1'b0;
            frameOk_q  <= 1'b0;
        end
    end

    // ****************************************************************
    // Global device state
    // ****************************************************************
    localparam logic [4:0] GLOBAL_RST_VAL = `GLOBAL_RST;
    logic addrState_q;
    logic config_q;
    logic sendRsmEn_q;
    logic rsmRcvd_q;
    logic wakeDrive_q;
    logic glbWr;

    assign glbWr = wrEn && hit(addr_q, `OFF_GLOBAL);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || busResetEnd)
        begin
            addrState_q <= GLOBAL_RST_VAL[`GS_ADDR_BIT];
        end
        else if (glbWr && hwdata[`GS_ADDR_BIT])
        begin
            addrState_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            config_q    <= GLOBAL_RST_VAL[`GS_CONF_BIT];
            sendRsmEn_q <= GLOBAL_RST_VAL[`GS_RSMEN_BIT];
            wakeDrive_q <= GLOBAL_RST_VAL[`GS_WAKE_BIT];
        end
        else if (glbWr)
        begin
            config_q    <= hwdata[`GS_CONF_BIT];
            sendRsmEn_q <= hwdata[`GS_RSMEN_BIT];
            wakeDrive_q <= hwdata[`GS_WAKE_BIT];
        end
    end

    // A host resume seen while waking remotely wins over the clear.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rsmRcvd_q <= GLOBAL_RST_VAL[`GS_RSM_BIT];
        end
        else if (hostResumeSeen && sendRsmEn_q && wakeDrive_q)
        begin
            rsmRcvd_q <= 1'b1;
        end
        else if (glbWr && !hwdata[`GS_WAKE_BIT])
        begin
            rsmRcvd_q <= 1'b0;
        end
    end

    assign driveKState     = wakeDrive_q && sendRsmEn_q;
    assign addressStateOut = addrState_q;
    assign configuredOut   = config_q;

    // ****************************************************************
    // Function address
    // ****************************************************************
    logic [6:0] funcAddr_q;
    logic       funcEn_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            funcAddr_q <= `FADDR_RST;
            funcEn_q   <= `FUNC_EN_RST;
        end
        else if (wrEn && hit(addr_q, `OFF_FADDR))
        begin
            funcAddr_q <= hwdata[6:0];
            funcEn_q   <= hwdata[`FA_EN_BIT];
        end
    end

    assign deviceAddress    = funcAddr_q;
    assign endpointsEnabled = funcEn_q;

    // ****************************************************************
    // Suspend detection
    // ****************************************************************
    logic [19:0] idleCnt_q;
    logic        suspended_q;
    logic        idleDone;
    logic        rsmPin_q;
    logic        extRise;

    assign idleDone = (idleCnt_q == 20'(IDLE_LIMIT - 1));
    assign extRise  = sendResumePin && !rsmPin_q && sendRsmEn_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || busActivity)
        begin
            idleCnt_q <= 20'h0_0000;
        end
        else if (!idleDone)
        begin
            idleCnt_q <= idleCnt_q + 20'h0_0001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || busActivity)
        begin
            suspended_q <= 1'b0;
        end
        else if (idleDone)
        begin
            suspended_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rsmPin_q <= 1'b0;
        end
        else
        begin
            rsmPin_q <= sendResumePin;
        end
    end

    assign suspendedOut = suspended_q;

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    usb_dev_pkg::irq_vec_t status_q;
    usb_dev_pkg::irq_vec_t mask_q;
    usb_dev_pkg::irq_vec_t events;
    usb_dev_pkg::irq_vec_t clrBits;
    usb_dev_pkg::irq_vec_t statusView;

    always_comb
    begin
        events = '0;
        events[`IRQ_SUSP_BIT] = idleDone && !suspended_q;
        events[`IRQ_RSM_BIT]  = hostResumeSeen;
        events[`IRQ_EXT_BIT]  = extRise && suspended_q;
        events[`IRQ_SOF_BIT]  = sofPidSeen;
        events[`IRQ_BRST_BIT] = busResetEnd;
        events[`IRQ_WAKE_BIT] = suspended_q && (hostResumeSeen || busResetEnd);
    end

    assign clrBits = (wrEn && hit(addr_q, `OFF_STAT_CLR)) ? hwdata[13:0] : '0;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            status_q <= `STAT_RST;
        end
        else
        begin
            status_q <= events | (status_q & ~clrBits);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mask_q <= `MASK_RST;
        end
        else if (wrEn && hit(addr_q, `OFF_IRQ_SET))
        begin
            mask_q <= mask_q | (hwdata[13:0] & `MASK_WR);
        end
        else if (wrEn && hit(addr_q, `OFF_IRQ_CLR))
        begin
            mask_q <= mask_q & ~(hwdata[13:0] & `MASK_WR);
        end
    end

    assign statusView = {status_q[13:6], endpointIrq};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(statusView & mask_q);
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [31:0] rdMux;

    always_comb
    begin
        rdMux = 32'h0000_0000;
        if (hit(addr_q, `OFF_FRAME))
        begin
            rdMux[10:0]          = frameNum_q;
            rdMux[`FRAME_ERR_BIT] = frameErr_q;
            rdMux[`FRAME_OK_BIT]  = frameOk_q;
        end
        else if (hit(addr_q, `OFF_FRAME_B8))
        begin
            rdMux[7:0]          = frameNum_q[7:0];
            rdMux[`B8_ERR_BIT]  = frameErr_q;
            rdMux[10:8]         = frameNum_q[10:8];
            rdMux[`B8_OK_BIT]   = frameOk_q;
        end
        else if (hit(addr_q, `OFF_GLOBAL))
        begin
            rdMux[`GS_ADDR_BIT] = addrState_q;
            rdMux[`GS_CONF_BIT] = config_q;
            rdMux[`GS_RSMEN_BIT] = sendRsmEn_q;
            rdMux[`GS_RSM_BIT]  = rsmRcvd_q;
            rdMux[`GS_WAKE_BIT] = wakeDrive_q;
        end
        else if (hit(addr_q, `OFF_FADDR))
        begin
            rdMux[6:0]          = funcAddr_q;
            rdMux[`FA_EN_BIT]   = funcEn_q;
        end
        else if (hit(addr_q, `OFF_IRQ_MASK))
        begin
            rdMux[13:0]         = mask_q;
        end
        else if (hit(addr_q, `OFF_IRQ_STAT))
        begin
            rdMux[13:0]         = statusView;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (phase_q == usb_dev_pkg::PH_READ_WAIT)
        begin
            rdata_q <= rdMux;
        end
    end

endmodule // usb_device_state_ctrl

// ### sim/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
    // Clock
    input wire logic    ref_clk,
    // Link events
    output logic        sofPidSeen,
    output logic        sofEopSeen,
    output logic        sofCrcError,
    output logic [10:0] frameNumberIn,
    output logic        busActivity,
    output logic        hostResumeSeen,
    output logic        busResetEnd
);
    // ***
    // Host stimulus
    // ***
    initial
    begin
        sofPidSeen = 1'b0;
        sofEopSeen = 1'b0;
        sofCrcError = 1'b1;
        frameNumberIn = 11'h7FF;
        busActivity = 1'b1;
        hostResumeSeen = 1'b0;
        busResetEnd = 1'b0;
    end

    task automatic sofPid();
        @(posedge ref_clk);
        sofPidSeen <= 1'b1;
        @(posedge ref_clk);
        sofPidSeen <= 1'b0;
    endtask

    // Number and error only mean something at end of packet, so they flip afterwards.
    task automatic sofEop(input logic [10:0] num, input logic err);
        @(posedge ref_clk);
        sofEopSeen <= 1'b1;
        frameNumberIn <= num;
        sofCrcError <= err;
        @(posedge ref_clk);
        sofEopSeen <= 1'b0;
        frameNumberIn <= ~num;
        sofCrcError <= ~err;
    endtask

    task automatic hostResume();
        @(posedge ref_clk);
        hostResumeSeen <= 1'b1;
        @(posedge ref_clk);
        hostResumeSeen <= 1'b0;
    endtask

    task automatic busReset();
        @(posedge ref_clk);
        busResetEnd <= 1'b1;
        @(posedge ref_clk);
        busResetEnd <= 1'b0;
    endtask

    task automatic setActive(input logic a);
        @(posedge ref_clk);
        busActivity <= a;
    endtask
endmodule // usb_host_model

// ### sim/usb_device_state_properties.sv
`timescale 1ns/1ps
module usb_device_state_properties #(
    parameter int IDLE_LIMIT = 50
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // Link and state
    input wire logic        busActivity,
    input wire logic        busResetEnd,
    input wire logic        driveKState,
    input wire logic        endpointsEnabled,
    input wire logic [6:0]  deviceAddress,
    input wire logic        addressStateOut,
    input wire logic        configuredOut,
    input wire logic        suspendedOut
);
    // ***
    // Helpers
    // ***
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic       wPend_q;
    logic [7:0] wAddr_q;
    int         idle_q;
    logic       glbWr;
    logic       addrWr;

    // High during the data phase of an accepted write.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            wPend_q <= 1'b0;
        else if (hready)
            wPend_q <= hsel & htrans[1] & hwrite;
    end

    always_ff @(posedge ref_clk)
    begin
        if (hready)
            wAddr_q <= haddr[7:0];
    end

    // Saturates just past the limit so it never wraps.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || busActivity)
            idle_q <= 0;
        else if (idle_q < IDLE_LIMIT + 4)
            idle_q <= idle_q + 1;
    end

    assign glbWr = wPend_q && wAddr_q == 8'h04;
    assign addrWr = wPend_q && wAddr_q == 8'h08;

    // ***
    // Properties
    // ***
    property p_addr_hold;
        addressStateOut && !busResetEnd |=> addressStateOut;
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address state lost");

    property p_addr_set;
        glbWr && hwdata[0] |=> addressStateOut;
    endproperty
    a_addr_set: assert property (p_addr_set)
        else $error("address state not set");

    property p_conf;
        glbWr |=> configuredOut == $past(hwdata[1]);
    endproperty
    a_conf: assert property (p_conf)
        else $error("configured state wrong");

    property p_kdrive;
        glbWr |=> driveKState == ($past(hwdata[4]) && $past(hwdata[2]));
    endproperty
    a_kdrive: assert property (p_kdrive)
        else $error("k state drive wrong");

    property p_faddr;
        addrWr |=> deviceAddress == $past(hwdata[6:0]);
    endproperty
    a_faddr: assert property (p_faddr)
        else $error("address value wrong");

    property p_fen;
        addrWr |=> endpointsEnabled == $past(hwdata[8]);
    endproperty
    a_fen: assert property (p_fen)
        else $error("function enable wrong");

    property p_susp_go;
        idle_q == IDLE_LIMIT + 2 |-> suspendedOut;
    endproperty
    a_susp_go: assert property (p_susp_go)
        else $error("suspend late");

    property p_susp_early;
        $rose(suspendedOut) |-> idle_q >= IDLE_LIMIT - 2;
    endproperty
    a_susp_early: assert property (p_susp_early)
        else $error("suspend early");
endmodule // usb_device_state_properties

bind usb_device_state_ctrl usb_device_state_properties #(
    .IDLE_LIMIT(IDLE_LIMIT)
) props_inst (
    .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .busActivity, .busResetEnd, .driveKState, .endpointsEnabled,
    .deviceAddress, .addressStateOut, .configuredOut, .suspendedOut
);

// ### sim/tb_top.sv
`timescale 1ns/1ps
`include "usb_dev_cfg.svh"
module tb_top;
    logic        ref_clk, rst_n, hsel, hwrite, hreadyout, sendResumePin, irq;
    logic        sofPidSeen, sofEopSeen, sofCrcError, busActivity;
    logic        hostResumeSeen, busResetEnd, driveKState, endpointsEnabled;
    logic        addressStateOut, configuredOut, suspendedOut, hresp;
    logic [1:0]  htrans;
    logic [5:0]  endpointIrq;
    logic [6:0]  deviceAddress;
    logic [10:0] frameNumberIn;
    logic [31:0] haddr, hwdata, hrdata;
    int          n_errors = 0;
    int          checks = 0;

    usb_device_state_ctrl #(
        .IDLE_LIMIT(50)
    ) usb_device_state_ctrl_inst (
        .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .sofPidSeen, .sofEopSeen, .sofCrcError, .frameNumberIn, .busActivity,
        .hostResumeSeen, .busResetEnd, .sendResumePin, .endpointIrq,
        .driveKState, .endpointsEnabled, .deviceAddress, .addressStateOut,
        .configuredOut, .suspendedOut, .irq
    );

    usb_host_model usb_host_model_inst (
        .ref_clk, .sofPidSeen, .sofEopSeen, .sofCrcError, .frameNumberIn,
        .busActivity, .hostResumeSeen, .busResetEnd
    );

    always #2 ref_clk = ~ref_clk;

    // ***
    // Common tasks
    // ***
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic waitRdy();
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_errors++;
            print_verdict();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        waitRdy();
        r = hrdata;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, r, e);
        chk({nm, " response"}, {31'h0, hresp}, 32'h0);
    endtask

    // The interrupt output lags a status event by two edges and an endpoint line by one.
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // ***
    // Scenarios
    // ***
    task automatic t_reset();
        logic [7:0]  a[7] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C, 8'h10, 8'h0C};
        logic [31:0] e[7] = '{32'h0, 32'h10, 32'h100, 32'h1200, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++)
            rdc("reset value", a[i], e[i]);
    endtask

    task automatic t_frame();
        usb_host_model_inst.sofPid();
        rdc("frame irq", 8'h1C, 32'h800);
        rdc("flags at pid", 8'h00, 32'h0);
        usb_host_model_inst.sofEop(11'h5A5, 1'b0);
        rdc("good frame", 8'h00, 32'h2_05A5);
        rdc("good bytes", 8'h78, 32'h15A5);
        usb_host_model_inst.sofPid();
        rdc("flags cleared", 8'h00, 32'h5A5);
        usb_host_model_inst.sofEop(11'h123, 1'b1);
        rdc("bad frame", 8'h00, 32'h1_0123);
        rdc("bad bytes", 8'h78, 32'h12B);
    endtask

    task automatic t_state();
        usb_host_model_inst.busReset();
        wr(8'h08, 32'h145);
        rdc("address reg", 8'h08, 32'h145);
        chk("address pins", {25'h0, deviceAddress}, 32'h45);
        wr(8'h04, 32'h1);
        wr(8'h04, 32'h0);
        rdc("address state", 8'h04, 32'h1);
        wr(8'h04, 32'h3);
        chk("configured", {31'h0, configuredOut}, 32'h1);
        wr(8'h04, 32'h1);
        rdc("unconfigured", 8'h04, 32'h1);
        wr(8'h04, 32'h15);
        chk("k drive", {31'h0, driveKState}, 32'h1);
        usb_host_model_inst.hostResume();
        rdc("resume seen", 8'h04, 32'h1D);
        wr(8'h04, 32'h11);
        chk("k blocked", {31'h0, driveKState}, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h45);
        chk("endpoints off", {31'h0, endpointsEnabled}, 32'h0);
        usb_host_model_inst.busReset();
        #1;
        chk("default state", {31'h0, addressStateOut}, 32'h0);
    endtask

    task automatic t_irq();
        wr(8'h14, 32'h3F3F);
        wr(8'h20, 32'h3F00);
        rdc("mask off", 8'h18, {18'h0, `MASK_RST & ~`MASK_WR});
        wr(8'h10, 32'h2F3F);
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h0);
        rdc("mask on", 8'h18, {18'h0, `MASK_RST | `MASK_WR});
        wr(8'h14, 32'h0F3F);
        rdc("mask part", 8'h18, {18'h0, (`MASK_RST | `MASK_WR) & ~14'h0F3F});
        @(posedge ref_clk);
        endpointIrq <= 6'h04;
        settle();
        chk("masked irq", {31'h0, irq}, 32'h0);
        wr(8'h10, 32'h4);
        settle();
        chk("open irq", {31'h0, irq}, 32'h1);
        @(posedge ref_clk);
        endpointIrq <= 6'h00;
        settle();
        chk("irq gone", {31'h0, irq}, 32'h0);
    endtask

    task automatic t_susp();
        int n;
        wr(8'h04, 32'h4);
        wr(8'h20, 32'h3F00);
        usb_host_model_inst.setActive(1'b0);
        for (n = 0; n < 100 && suspendedOut !== 1'b1; n++)
            @(posedge ref_clk);
        chk("suspended", {31'h0, suspendedOut}, 32'h1);
        if (suspendedOut !== 1'b1)
            print_verdict();
        sendResumePin <= 1'b1;
        settle();
        usb_host_model_inst.hostResume();
        usb_host_model_inst.setActive(1'b1);
        sendResumePin <= 1'b0;
        settle();
        chk("awake", {31'h0, suspendedOut}, 32'h0);
        rdc("suspend events", 8'h1C, 32'h2700);
    endtask

    initial
    begin
        #200000;
        n_errors++;
        print_verdict();
    end

    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        sendResumePin = 1'b0;
        endpointIrq = 6'h00;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_frame();
        t_state();
        t_irq();
        t_susp();
        print_verdict();
    end
endmodule // tb_top
